/* pkg/clk_rst_pkg.sv */
// Package of register map, field layout and encodings for the clock and reset unit.
package clk_rst_pkg;

	localparam logic [7:0] OFF_STATUS = 8'h00;
	localparam logic [7:0] OFF_IRQ_EN = 8'h04;
	localparam logic [7:0] OFF_IRQ_STS = 8'h08;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h10;
	localparam logic [7:0] OFF_PLL_CTRL = 8'h18;
	localparam logic [7:0] OFF_DIV_A = 8'h20;
	localparam logic [7:0] OFF_DIV_B = 8'h24;
	localparam logic [7:0] OFF_DIV_C = 8'h28;
	localparam logic [7:0] OFF_DIV_D = 8'h2C;
	localparam logic [7:0] OFF_SYS_CLK = 8'h30;
	localparam logic [7:0] OFF_RESET_CTRL = 8'h34;

	// Status bit positions.
	localparam int ST_XTAL_RDY = 1;
	localparam int ST_PLL_LOCK = 4;
	localparam int ST_PLL_UNLOCK = 5;
	localparam int ST_DIV_A_RDY = 8;
	localparam int ST_SYS_RDY = 16;

	// Writable field masks per register.
	localparam logic [31:0] MASK_OSC = 32'h0000_0007;
	localparam logic [31:0] MASK_PLL = 32'h3FFF_3FE3;
	localparam logic [31:0] MASK_DIV_A = 32'h0000_0303;
	localparam logic [31:0] MASK_DIV_BC = 32'h0000_0707;
	localparam logic [31:0] MASK_DIV_D = 32'h0000_7F07;
	localparam logic [31:0] MASK_SYS = 32'h0000_0007;
	localparam logic [31:0] MASK_RST = 32'h0000_0001;
	localparam logic [31:0] MASK_STATUS = 32'h0057_0F32;

	localparam int OSC_CRYSTAL_ENABLE = 0;
	localparam int OSC_BYPASS = 1;
	localparam int OSC_FAST_EN = 2;
	localparam int PLL_USED_BIT = 4;
	localparam int PLL_EN_BIT = 5;
	localparam int PLL_BYP_BIT = 6;
	localparam int PLL_RST_BIT = 7;
	localparam int USED_BIT = 4;
	localparam int DIV_D_ON_BIT = 14;

	localparam logic [2:0] SRC_SLOW = 3'h0;
	localparam logic [2:0] SRC_FAST = 3'h1;
	localparam logic [2:0] SRC_XTAL = 3'h2;
	localparam logic [2:0] SRC_PLL = 3'h3;
	localparam logic [2:0] SRC_DIV_A = 3'h4;
	localparam logic [2:0] SRC_DIV_B = 3'h5;
	localparam logic [2:0] SRC_DIV_C = 3'h6;
	localparam logic [2:0] SRC_RSVD = 3'h7;
	localparam logic [2:0] DIV_C_MAX = 3'h5;

	localparam int NUM_DIV = 4;
	localparam int SETTLE_W = 4;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	typedef struct packed {
		logic sys_n;
		logic sysctrl_n;
		logic core_test_n;
		logic nvm_test_n;
	} reset_out_s;

endpackage : clk_rst_pkg

/* design/clk_settle.sv */
// Settle timer that raises a ready flag once a clock change has taken effect.
`timescale 1ns/10ps
module clk_settle #(
	parameter int CYCLES = 8
) (
	input wire logic clk_i, // Clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic ce_i, // Clock enable.
	input wire logic restart_i, // Change request, drops ready.
	input wire logic running_i, // Output clock is running.
	output logic ready_o // Change has taken effect.
);
	logic [clk_rst_pkg::SETTLE_W-1:0] cnt_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= '0;
			ready_o <= 1'b0;
		end else if (ce_i) begin
			if (restart_i) begin
				cnt_reg <= '0;
				ready_o <= 1'b0;
			end else if (!running_i) begin
				ready_o <= 1'b0;
			end else if (cnt_reg == clk_rst_pkg::SETTLE_W'(CYCLES - 1)) begin
				ready_o <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

endmodule : clk_settle

/* design/clock_reset_unit.sv */
// Clock and reset unit: register bank, source selection, ready status and reset lines.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module clock_reset_unit #(
	parameter int SETTLE_CYCLES = 8
) (
	input wire logic REF_CLK_I, // 125 MHz clock.
	input wire logic RESET_N_I, // Asynchronous reset, active low.
	input wire logic CLK_EN_I, // Clock enable, freezes all state.
	input wire logic [7:0] ADDR_I, // Register byte address.
	input wire logic [31:0] WDATA_I, // Write data.
	input wire logic WR_I, // Write strobe.
	input wire logic RD_I, // Read strobe.
	output logic [31:0] RDATA_O, // Read data, cycle after strobe.
	input wire logic [3:0] OSC_RUN_I, // Running: slow, fast, crystal, PLL lock.
	input wire logic CLK_FAULT_I, // Clock monitor fault.
	input wire logic STANDBY_I, // Standby entry.
	input wire logic WAKEUP_I, // Wakeup from standby.
	input wire logic GROUP_RST_I, // Peripheral group reset command.
	input wire logic PIN_RST_N_I, // External reset pin, active low.
	output logic [31:0] OSC_CTRL_O, // Oscillator control.
	output logic [31:0] PLL_CTRL_O, // PLL control.
	output logic [2:0] SYS_SRC_O, // Active system clock source.
	output logic [7:0] DIV_CFG_O, // Divider ready and running flags.
	output logic SYS_RST_N_O, // System reset, active low.
	output logic SYSCTRL_RST_N_O, // Controller reset, active low.
	output logic CORE_TEST_RST_N_O, // Core test reset, active low.
	output logic NVM_TEST_RST_N_O // NVM test reset, active low.
);
	clk_rst_pkg::bus_req_s req;
	clk_rst_pkg::reset_out_s rst_reg;
	logic [31:0] osc_reg, pll_reg, sys_reg, irq_en_reg, irq_sts_reg, prev_sts_reg;
	logic [31:0] div_reg [clk_rst_pkg::NUM_DIV];
	logic [31:0] status, rdata_next;
	logic [2:0] sys_active_reg;
	logic [clk_rst_pkg::NUM_DIV-1:0] div_run, div_rdy, div_wr;
	logic sys_rdy, pll_rdy, soft_rst_reg, fault_reg;

	assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

	function automatic logic src_run(input logic [2:0] s, input logic [3:0] osc,
			input logic [3:0] dv);
		logic r;
		r = 1'b0;
		case (s)
			clk_rst_pkg::SRC_SLOW: r = osc[0];
			clk_rst_pkg::SRC_FAST: r = osc[1];
			clk_rst_pkg::SRC_XTAL: r = osc[2];
			clk_rst_pkg::SRC_PLL: r = osc[3];
			clk_rst_pkg::SRC_DIV_A: r = dv[0];
			clk_rst_pkg::SRC_DIV_B: r = dv[1];
			clk_rst_pkg::SRC_DIV_C: r = dv[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction : src_run

	// ****************************************************************
	// Register writes
	// ****************************************************************

	function automatic logic uses(input logic [2:0] s, input logic [2:0] target,
			input logic [31:0] sel);
		return s == target || sel[2:0] == target;
	endfunction : uses

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			osc_reg <= '0;
			pll_reg <= '0;
			sys_reg <= '0;
			irq_en_reg <= '0;
			soft_rst_reg <= 1'b0;
		end else if (CLK_EN_I && req.wr) begin
			case (req.addr)
				clk_rst_pkg::OFF_IRQ_EN: irq_en_reg <= req.wdata & clk_rst_pkg::MASK_STATUS;
				clk_rst_pkg::OFF_OSC_CTRL: begin
					osc_reg <= req.wdata & clk_rst_pkg::MASK_OSC;
					// A source selected as the active system clock or in pll_reg bits 2:0 keeps its enable.
					if (uses(sys_active_reg, clk_rst_pkg::SRC_XTAL, pll_reg)) begin
						osc_reg[clk_rst_pkg::OSC_CRYSTAL_ENABLE] <= 1'b1;
					end
					if (uses(sys_active_reg, clk_rst_pkg::SRC_FAST, pll_reg)) begin
						osc_reg[clk_rst_pkg::OSC_FAST_EN] <= 1'b1;
					end
				end
				clk_rst_pkg::OFF_PLL_CTRL: begin
					pll_reg <= req.wdata & clk_rst_pkg::MASK_PLL;
					if (sys_active_reg == clk_rst_pkg::SRC_PLL) begin
						pll_reg[clk_rst_pkg::PLL_EN_BIT] <= 1'b1;
					end
				end
				clk_rst_pkg::OFF_SYS_CLK: sys_reg <= req.wdata & clk_rst_pkg::MASK_SYS;
				clk_rst_pkg::OFF_RESET_CTRL: soft_rst_reg <= req.wdata[0];
				default: ;
			endcase
		end
	end

	// ****************************************************************
	// Dividers A to D
	// ****************************************************************

	localparam logic [31:0] DIV_MASK [clk_rst_pkg::NUM_DIV] = '{clk_rst_pkg::MASK_DIV_A,
		clk_rst_pkg::MASK_DIV_BC, clk_rst_pkg::MASK_DIV_BC, clk_rst_pkg::MASK_DIV_D};
	localparam logic [7:0] DIV_OFF [clk_rst_pkg::NUM_DIV] = '{clk_rst_pkg::OFF_DIV_A,
		clk_rst_pkg::OFF_DIV_B, clk_rst_pkg::OFF_DIV_C, clk_rst_pkg::OFF_DIV_D};

	localparam int USED = clk_rst_pkg::USED_BIT;

	genvar g;
	generate
		for (g = 0; g < clk_rst_pkg::NUM_DIV; g++) begin : gen_div
			logic [31:0] w;
			logic legal;
			logic src_ok;
			assign w = req.wdata & DIV_MASK[g];
			assign div_wr[g] = CLK_EN_I && req.wr && req.addr == DIV_OFF[g];
			always_comb begin
				legal = 1'b1;
				case (g)
					0: legal = w[2:0] <= clk_rst_pkg::SRC_PLL;
					1, 2: legal = w[2:0] <= clk_rst_pkg::SRC_DIV_A;
					default: legal = w[2:0] != clk_rst_pkg::SRC_RSVD;
				endcase
				if (g == 2 && w[10:8] > clk_rst_pkg::DIV_C_MAX) begin
					legal = 1'b0;
				end
			end
			// A divider output runs only while the source selected in its bits 2:0 runs.
			assign src_ok = src_run(div_reg[g][2:0], OSC_RUN_I, div_run);
			always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
				if (!RESET_N_I) begin
					div_reg[g] <= '0;
				end else if (div_wr[g] && legal) begin
					div_reg[g] <= w;
					div_reg[g][USED] <= div_reg[g][USED];
				end else if (CLK_EN_I) begin
					div_reg[g][USED] <= uses(sys_active_reg, 3'(4 + g), 32'h0000_0000);
				end
			end
			always_comb begin
				case (g)
					0: div_run[g] = src_ok && div_reg[g][9:8] != 2'h0;
					1: div_run[g] = src_ok && div_reg[g][10:8] != 3'h0;
					2: div_run[g] = src_ok && div_reg[g][10:8] != 3'h0;
					default: div_run[g] = src_ok && div_reg[g][clk_rst_pkg::DIV_D_ON_BIT];
				endcase
			end
			clk_settle #(.CYCLES(SETTLE_CYCLES)) u_settle (
				.clk_i(REF_CLK_I),
				.rst_n_i(RESET_N_I),
				.ce_i(CLK_EN_I),
				.restart_i(div_wr[g]),
				.running_i(div_run[g]),
				.ready_o(div_rdy[g])
			);
		end
	endgenerate

	// ****************************************************************
	// System clock selection and PLL ready
	// ****************************************************************

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sys_active_reg <= clk_rst_pkg::SRC_SLOW;
			fault_reg <= 1'b0;
		end else if (CLK_EN_I) begin
			fault_reg <= CLK_FAULT_I;
			if (CLK_FAULT_I) begin
				sys_active_reg <= clk_rst_pkg::SRC_SLOW;
			end else if (sys_reg[2:0] != sys_active_reg
					&& src_run(sys_reg[2:0], OSC_RUN_I, div_run)
					&& src_run(sys_active_reg, OSC_RUN_I, div_run)) begin
				sys_active_reg <= sys_reg[2:0];
			end
		end
	end

	clk_settle #(.CYCLES(SETTLE_CYCLES)) u_sys_settle (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESET_N_I),
		.ce_i(CLK_EN_I),
		.restart_i(CLK_EN_I && req.wr && req.addr == clk_rst_pkg::OFF_SYS_CLK),
		.running_i(sys_active_reg == sys_reg[2:0] && !fault_reg),
		.ready_o(sys_rdy)
	);

	clk_settle #(.CYCLES(SETTLE_CYCLES)) u_pll_settle (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESET_N_I),
		.ce_i(CLK_EN_I),
		.restart_i(CLK_EN_I && req.wr && req.addr == clk_rst_pkg::OFF_PLL_CTRL),
		.running_i(OSC_RUN_I[3] && pll_reg[clk_rst_pkg::PLL_EN_BIT]
			&& !pll_reg[clk_rst_pkg::PLL_RST_BIT]),
		.ready_o(pll_rdy)
	);

	always_comb begin
		status = '0;
		status[clk_rst_pkg::ST_XTAL_RDY] = OSC_RUN_I[2] && osc_reg[clk_rst_pkg::OSC_CRYSTAL_ENABLE];
		status[clk_rst_pkg::ST_PLL_LOCK] = pll_rdy;
		status[clk_rst_pkg::ST_PLL_UNLOCK] = pll_reg[clk_rst_pkg::PLL_EN_BIT] && !pll_rdy;
		status[clk_rst_pkg::ST_DIV_A_RDY +: clk_rst_pkg::NUM_DIV] = div_rdy;
		status[clk_rst_pkg::ST_SYS_RDY] = sys_rdy;
	end

	// ****************************************************************
	// Interrupt status
	// ****************************************************************

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			prev_sts_reg <= '0;
			irq_sts_reg <= '0;
		end else if (CLK_EN_I) begin
			prev_sts_reg <= status;
			// New rising events win over a simultaneous clear.
			irq_sts_reg <= ((irq_sts_reg & ~((req.wr && req.addr == clk_rst_pkg::OFF_IRQ_STS)
				? req.wdata : 32'h0000_0000))
				| (status & ~prev_sts_reg)) & irq_en_reg;
		end
	end

	// ****************************************************************
	// Read port and outputs
	// ****************************************************************

	always_comb begin
		case (req.addr)
			clk_rst_pkg::OFF_STATUS: rdata_next = status;
			clk_rst_pkg::OFF_IRQ_EN: rdata_next = irq_en_reg;
			clk_rst_pkg::OFF_IRQ_STS: rdata_next = irq_sts_reg & irq_en_reg;
			clk_rst_pkg::OFF_OSC_CTRL: rdata_next = osc_reg;
			clk_rst_pkg::OFF_PLL_CTRL: begin
				rdata_next = pll_reg;
				rdata_next[clk_rst_pkg::PLL_USED_BIT] = sys_active_reg == clk_rst_pkg::SRC_PLL;
			end
			clk_rst_pkg::OFF_DIV_A: rdata_next = div_reg[0];
			clk_rst_pkg::OFF_DIV_B: rdata_next = div_reg[1];
			clk_rst_pkg::OFF_DIV_C: rdata_next = div_reg[2];
			clk_rst_pkg::OFF_DIV_D: rdata_next = div_reg[3];
			clk_rst_pkg::OFF_SYS_CLK: rdata_next = {29'h0000_0000, sys_active_reg};
			clk_rst_pkg::OFF_RESET_CTRL: rdata_next = {31'h0000_0000, soft_rst_reg};
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= '0;
			OSC_CTRL_O <= '0;
			PLL_CTRL_O <= '0;
			SYS_SRC_O <= clk_rst_pkg::SRC_SLOW;
			DIV_CFG_O <= '0;
		end else if (CLK_EN_I) begin
			RDATA_O <= req.rd ? rdata_next : 32'h0000_0000;
			OSC_CTRL_O <= osc_reg;
			PLL_CTRL_O <= pll_reg;
			SYS_SRC_O <= sys_active_reg;
			DIV_CFG_O <= {div_rdy, div_run};
		end
	end

	// ****************************************************************
	// Reset lines
	// ****************************************************************

	always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			rst_reg <= '0;
		end else if (CLK_EN_I) begin
			rst_reg.sys_n <= !(soft_rst_reg || GROUP_RST_I);
			rst_reg.sysctrl_n <= !soft_rst_reg;
			rst_reg.core_test_n <= PIN_RST_N_I;
			rst_reg.nvm_test_n <= PIN_RST_N_I;
		end
	end

	assign SYS_RST_N_O = rst_reg.sys_n;
	assign SYSCTRL_RST_N_O = rst_reg.sysctrl_n;
	assign CORE_TEST_RST_N_O = rst_reg.core_test_n;
	assign NVM_TEST_RST_N_O = rst_reg.nvm_test_n;

endmodule : clock_reset_unit

/* test/clock_reset_monitor.sv */
// Concurrent checks on the ports of the clock and reset unit.
`timescale 1ns/10ps
module clock_reset_monitor #(
	parameter int SETTLE_CYCLES = 8
) (
	input wire logic REF_CLK_I, // Clock.
	input wire logic RESET_N_I, // Reset, active low.
	input wire logic CLK_EN_I, // Clock enable.
	input wire logic [7:0] ADDR_I, // Address.
	input wire logic [31:0] WDATA_I, // Write data.
	input wire logic WR_I, // Write strobe.
	input wire logic RD_I, // Read strobe.
	input wire logic [31:0] RDATA_O, // Read data.
	input wire logic [3:0] OSC_RUN_I, // Running flags.
	input wire logic CLK_FAULT_I, // Clock fault.
	input wire logic GROUP_RST_I, // Group reset.
	input wire logic PIN_RST_N_I, // Reset pin.
	input wire logic [31:0] OSC_CTRL_O, // Oscillator control.
	input wire logic [31:0] PLL_CTRL_O, // PLL control.
	input wire logic [2:0] SYS_SRC_O, // System source.
	input wire logic [7:0] DIV_CFG_O, // Divider flags.
	input wire logic SYS_RST_N_O, // System reset.
	input wire logic CORE_TEST_RST_N_O, // Core test reset.
	input wire logic NVM_TEST_RST_N_O // NVM test reset.
);
	logic wr_en;
	logic rd_en;
	assign wr_en = CLK_EN_I && WR_I;
	assign rd_en = CLK_EN_I && RD_I;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	sequence s_wr_diva;
		wr_en && ADDR_I == clk_rst_pkg::OFF_DIV_A;
	endsequence
	sequence s_rd_sts;
		rd_en && ADDR_I == clk_rst_pkg::OFF_STATUS;
	endsequence
	a_ready_drop: assert property (s_wr_diva |-> ##2 !DIV_CFG_O[4])
		else $error("divider A ready stayed up after a write");
	a_ready_read: assert property (s_wr_diva ##2 s_rd_sts |=> !RDATA_O[8])
		else $error("status shows divider A ready too early");
	a_read_idle: assert property (CLK_EN_I && !RD_I |=> RDATA_O == 32'h0000_0000)
		else $error("read data outside the read cycle");
	a_read_hole: assert property (rd_en && ADDR_I == 8'h0C |=> RDATA_O == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_fault_safe: assert property (CLK_FAULT_I && CLK_EN_I |-> ##2 SYS_SRC_O == 3'h0)
		else $error("fault did not select the slow clock");
	a_switch_run: assert property (!$stable(SYS_SRC_O) && SYS_SRC_O <= 3'h3 && !$past(CLK_FAULT_I, 2)
		|-> ($past(OSC_RUN_I, 2) & (4'h1 << SYS_SRC_O[1:0])) != 4'h0)
		else $error("switched to a stopped clock");
	a_osc_write: assert property (wr_en && ADDR_I == clk_rst_pkg::OFF_OSC_CTRL
		&& SYS_SRC_O == clk_rst_pkg::SRC_SLOW && (WDATA_I & 32'h0000_0005) == 32'h0000_0005
		|-> ##2 OSC_CTRL_O == ($past(WDATA_I, 2) & clk_rst_pkg::MASK_OSC))
		else $error("oscillator control not taken");
	a_pll_write: assert property (wr_en && ADDR_I == clk_rst_pkg::OFF_PLL_CTRL && WDATA_I[5]
		|-> ##2 ((PLL_CTRL_O ^ $past(WDATA_I, 2)) & clk_rst_pkg::MASK_PLL) == 32'h0000_0000)
		else $error("PLL control fields not taken");
	a_group_sys: assert property (GROUP_RST_I && CLK_EN_I |=> !SYS_RST_N_O)
		else $error("group reset did not assert system reset");
	a_test_pin: assert property (CLK_EN_I |=> CORE_TEST_RST_N_O == $past(PIN_RST_N_I)
		&& NVM_TEST_RST_N_O == $past(PIN_RST_N_I))
		else $error("test resets do not follow the reset pin");
endmodule : clock_reset_monitor

bind clock_reset_unit clock_reset_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) mon (
	.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .CLK_EN_I(CLK_EN_I), .ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .OSC_RUN_I(OSC_RUN_I),
	.CLK_FAULT_I(CLK_FAULT_I), .GROUP_RST_I(GROUP_RST_I), .PIN_RST_N_I(PIN_RST_N_I),
	.OSC_CTRL_O(OSC_CTRL_O), .PLL_CTRL_O(PLL_CTRL_O), .SYS_SRC_O(SYS_SRC_O),
	.DIV_CFG_O(DIV_CFG_O), .SYS_RST_N_O(SYS_RST_N_O),
	.CORE_TEST_RST_N_O(CORE_TEST_RST_N_O), .NVM_TEST_RST_N_O(NVM_TEST_RST_N_O));

/* test/clock_reset_unit_tb_top.sv */
// Self-checking bench for the clock and reset unit.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module clock_reset_unit_tb_top;
	logic REF_CLK_I = 1'b0;
	logic RESET_N_I = 1'b0;
	logic CLK_EN_I = 1'b1;
	logic [7:0] ADDR_I = 8'h00;
	logic [31:0] WDATA_I = 32'h0000_0000;
	logic WR_I = 1'b0;
	logic RD_I = 1'b0;
	logic [3:0] OSC_RUN_I = 4'hF;
	logic CLK_FAULT_I = 1'b0;
	logic STANDBY_I = 1'b0;
	logic WAKEUP_I = 1'b0;
	logic GROUP_RST_I = 1'b0;
	logic PIN_RST_N_I = 1'b1;
	logic [31:0] RDATA_O;
	logic [2:0] SYS_SRC_O;
	logic SYS_RST_N_O;
	logic SYSCTRL_RST_N_O;
	logic CORE_TEST_RST_N_O;
	logic NVM_TEST_RST_N_O;
	int failures = 0;
	int checked = 0;
	logic [31:0] v;
	logic [7:0] offs [13] = '{8'h04, 8'h10, 8'h18, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34,
		8'h0C, 8'h14, 8'h1C, 8'h40};
	always #4 REF_CLK_I = ~REF_CLK_I;
	clock_reset_unit #(.SETTLE_CYCLES(4)) uut (
		.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .CLK_EN_I(CLK_EN_I), .ADDR_I(ADDR_I),
		.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .OSC_RUN_I(OSC_RUN_I),
		.CLK_FAULT_I(CLK_FAULT_I), .STANDBY_I(STANDBY_I), .WAKEUP_I(WAKEUP_I),
		.GROUP_RST_I(GROUP_RST_I), .PIN_RST_N_I(PIN_RST_N_I), .OSC_CTRL_O(), .PLL_CTRL_O(),
		.SYS_SRC_O(SYS_SRC_O), .DIV_CFG_O(), .SYS_RST_N_O(SYS_RST_N_O),
		.SYSCTRL_RST_N_O(SYSCTRL_RST_N_O), .CORE_TEST_RST_N_O(CORE_TEST_RST_N_O),
		.NVM_TEST_RST_N_O(NVM_TEST_RST_N_O));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		WDATA_I <= d;
		WR_I <= 1'b1;
		@(posedge REF_CLK_I);
		WR_I <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge REF_CLK_I);
		RD_I <= 1'b0;
		#1;
		d = RDATA_O;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK_I);
		#1;
	endtask : cyc
	task automatic wait_rdy(input int b);
		for (int i = 0; i < 100; i++) begin
			rd(clk_rst_pkg::OFF_STATUS, v);
			if (v[b] === 1'b1) break;
		end
		`CHK(v[b], 1'b1)
	endtask : wait_rdy
	task automatic end_of_test();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20000) @(posedge REF_CLK_I);
		failures++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge REF_CLK_I);
		RESET_N_I <= 1'b1;
		cyc(1);
		`CHK(SYS_SRC_O, clk_rst_pkg::SRC_SLOW)
		foreach (offs[i]) begin
			rd(offs[i], v);
			`CHK(v, 32'h0000_0000)
		end
		wr(clk_rst_pkg::OFF_PLL_CTRL, 32'h3FFF_3FE3);
		rd(clk_rst_pkg::OFF_PLL_CTRL, v);
		`CHK(v & clk_rst_pkg::MASK_PLL, 32'h3FFF_3FE3)
		wr(clk_rst_pkg::OFF_IRQ_EN, 32'h0000_0100);
		rd(clk_rst_pkg::OFF_IRQ_EN, v);
		`CHK(v, 32'h0000_0100)
		wr(clk_rst_pkg::OFF_DIV_A, 32'h0000_0101);
		wait_rdy(8);
		wr(clk_rst_pkg::OFF_IRQ_STS, 32'h0000_0000);
		rd(clk_rst_pkg::OFF_IRQ_STS, v);
		`CHK(v, 32'h0000_0100)
		wr(clk_rst_pkg::OFF_IRQ_STS, 32'h0000_0100);
		rd(clk_rst_pkg::OFF_IRQ_STS, v);
		`CHK(v, 32'h0000_0000)
		wr(clk_rst_pkg::OFF_IRQ_EN, 32'h0000_0000);
		CLK_EN_I <= 1'b0;
		wr(clk_rst_pkg::OFF_IRQ_EN, 32'h0000_0100);
		CLK_EN_I <= 1'b1;
		rd(clk_rst_pkg::OFF_IRQ_EN, v);
		`CHK(v, 32'h0000_0000)
		wr(clk_rst_pkg::OFF_DIV_A, 32'h0000_0201);
		wait_rdy(8);
		rd(clk_rst_pkg::OFF_IRQ_STS, v);
		`CHK(v, 32'h0000_0000)
		rd(clk_rst_pkg::OFF_DIV_A, v);
		`CHK(v & clk_rst_pkg::MASK_DIV_A, 32'h0000_0201)
		for (int s = 0; s < 5; s++) begin
			wr(clk_rst_pkg::OFF_DIV_B, 32'h0000_0300 | s);
			wait_rdy(9);
			rd(clk_rst_pkg::OFF_DIV_B, v);
			`CHK(v & clk_rst_pkg::MASK_DIV_BC, 32'h0000_0300 | s)
		end
		wr(clk_rst_pkg::OFF_DIV_B, 32'h0000_0305);
		rd(clk_rst_pkg::OFF_DIV_B, v);
		`CHK(v & clk_rst_pkg::MASK_DIV_BC, 32'h0000_0304)
		wr(clk_rst_pkg::OFF_DIV_C, 32'h0000_0500);
		wait_rdy(10);
		wr(clk_rst_pkg::OFF_DIV_C, 32'h0000_0600);
		rd(clk_rst_pkg::OFF_DIV_C, v);
		`CHK(v & clk_rst_pkg::MASK_DIV_BC, 32'h0000_0500)
		wr(clk_rst_pkg::OFF_DIV_D, 32'h0000_7F06);
		wait_rdy(11);
		rd(clk_rst_pkg::OFF_DIV_D, v);
		`CHK(v & clk_rst_pkg::MASK_DIV_D, 32'h0000_7F06)
		wr(clk_rst_pkg::OFF_OSC_CTRL, 32'h0000_0005);
		wait_rdy(1);
		OSC_RUN_I <= 4'b1011;
		wr(clk_rst_pkg::OFF_SYS_CLK, 32'h0000_0002);
		cyc(20);
		`CHK(SYS_SRC_O, clk_rst_pkg::SRC_SLOW)
		rd(clk_rst_pkg::OFF_SYS_CLK, v);
		`CHK(v, 32'h0000_0000)
		OSC_RUN_I <= 4'hF;
		for (int i = 0; i < 50 && SYS_SRC_O !== clk_rst_pkg::SRC_XTAL; i++) cyc(1);
		`CHK(SYS_SRC_O, clk_rst_pkg::SRC_XTAL)
		wr(clk_rst_pkg::OFF_OSC_CTRL, 32'h0000_0000);
		rd(clk_rst_pkg::OFF_OSC_CTRL, v);
		`CHK(v, 32'h0000_0001)
		CLK_FAULT_I <= 1'b1;
		cyc(5);
		`CHK(SYS_SRC_O, clk_rst_pkg::SRC_SLOW)
		CLK_FAULT_I <= 1'b0;
		STANDBY_I <= 1'b1;
		cyc(4);
		`CHK(SYS_RST_N_O, 1'b1)
		STANDBY_I <= 1'b0;
		GROUP_RST_I <= 1'b1;
		WAKEUP_I <= 1'b1;
		cyc(3);
		`CHK({SYS_RST_N_O, SYSCTRL_RST_N_O}, 2'b01)
		`CHK({CORE_TEST_RST_N_O, NVM_TEST_RST_N_O}, 2'b11)
		GROUP_RST_I <= 1'b0;
		WAKEUP_I <= 1'b0;
		wr(clk_rst_pkg::OFF_RESET_CTRL, 32'h0000_0001);
		cyc(2);
		`CHK({SYS_RST_N_O, CORE_TEST_RST_N_O, NVM_TEST_RST_N_O}, 3'b011)
		wr(clk_rst_pkg::OFF_RESET_CTRL, 32'h0000_0000);
		PIN_RST_N_I <= 1'b0;
		cyc(3);
		`CHK({CORE_TEST_RST_N_O, NVM_TEST_RST_N_O}, 2'b00)
		PIN_RST_N_I <= 1'b1;
		cyc(3);
		`CHK({SYS_RST_N_O, CORE_TEST_RST_N_O}, 2'b11)
		end_of_test();
	end
endmodule : clock_reset_unit_tb_top
